// ### verilog/cnsc_status.sv
// node status code generator, master and slave code sets
`timescale 1ns/1ns
// Notes on behaviour
// - master normal or inactive reports zero
// - master empty node list reports F1
// - master download in progress reports F2
// - master bad configuration F3 until redownload
// - bus-off reports F4 either role
// - master own node address outside 1-127 reports F5
// - master internal memory fault reports F8
// - transmit buffer full reports FB
// - receive buffer full reports FC
// - slave initializing reports A0
// - slave pre-operational reports A1
// - slave download in progress reports A3
// - slave PDO length mismatch reports B1
module cnsc_status
  import cnsc_pkg::*;
#(
  parameter int TICK_CYC = CNSC_TICK_CYC
)
(
  // clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        rst_n_in,
  // role
  input  wire logic        master_role_in,
  input  wire logic        master_active_in,
  // configuration
  input  wire logic [6:0]  slave_count_in,
  input  wire logic        cfg_loading_in,
  input  wire logic        cfg_done_in,
  input  wire logic        cfg_bad_in,
  input  wire logic [7:0]  own_node_id_in,
  // controller condition
  input  wire logic        bus_off_in,
  input  wire logic        mem_fault_in,
  input  wire logic        tx_full_in,
  input  wire logic        rx_full_in,
  // slave node state
  input  wire logic        initializing_in,
  input  wire logic        preop_in,
  input  wire logic        pdo_len_bad_in,
  input  wire logic        hb_enable_in,
  input  wire logic [15:0] hb_time_ms_in,
  input  wire logic        hb_seen_in,
  // status
  output logic [7:0]       network_state_code_register_out
);

  typedef struct packed {
    logic       cfg_err;
    logic [7:0] code;
  } cnsc_state_type;

  cnsc_state_type state_ff;
  cnsc_state_type nxt_state;
  logic           hb_tout;

  // missed heartbeat detection kept apart for its long count
  cnsc_hb_monitor #(.TICK_CYC(TICK_CYC)) u_hb (
    .ref_clk_in     (ref_clk_in),
    .rst_n_in       (rst_n_in),
    .hb_enable_in   (hb_enable_in && !master_role_in),
    .hb_time_ms_in  (hb_time_ms_in),
    .hb_seen_in     (hb_seen_in),
    .hb_timeout_out (hb_tout)
  );

  // true when the own address lies outside the legal 1..127 range
  function automatic logic id_bad(input logic [7:0] id);
    return (id < CNSC_NODE_MIN) || (id > CNSC_NODE_MAX);
  endfunction

  // priority: master inactive first, then hard faults and a bad own address, then buffers, then configuration/state
  always_comb
  begin
    nxt_state = state_ff;
    // sticky bad-config flag, cleared only by a new download start
    if (cfg_bad_in)
      nxt_state.cfg_err = 1'b1;
    else if (cfg_loading_in)
      nxt_state.cfg_err = 1'b0;
    if (master_role_in)
    begin
      if (!master_active_in)
        nxt_state.code = CNSC_CODE_OK;
      else if (mem_fault_in)
        nxt_state.code = CNSC_CODE_MEM_ERR;
      else if (bus_off_in)
        nxt_state.code = CNSC_CODE_BUS_OFF;
      else if (id_bad(own_node_id_in))
        nxt_state.code = CNSC_CODE_BAD_SET;
      else if (tx_full_in)
        nxt_state.code = CNSC_CODE_TX_FULL;
      else if (rx_full_in)
        nxt_state.code = CNSC_CODE_RX_FULL;
      else if (cfg_loading_in && !cfg_done_in)
        nxt_state.code = CNSC_CODE_M_LOAD;
      else if (state_ff.cfg_err || cfg_bad_in)
        nxt_state.code = CNSC_CODE_CFG_ERR;
      else if (slave_count_in == 7'h00)
        nxt_state.code = CNSC_CODE_NO_SLAVE;
      else
        nxt_state.code = CNSC_CODE_OK;
    end
    else
    begin
      if (bus_off_in)
        nxt_state.code = CNSC_CODE_BUS_OFF;
      else if (tx_full_in)
        nxt_state.code = CNSC_CODE_TX_FULL;
      else if (rx_full_in)
        nxt_state.code = CNSC_CODE_RX_FULL;
      else if (initializing_in)
        nxt_state.code = CNSC_CODE_INIT;
      else if (cfg_loading_in && !cfg_done_in)
        nxt_state.code = CNSC_CODE_S_LOAD;
      else if (hb_tout)
        nxt_state.code = CNSC_CODE_HB_TOUT;
      else if (pdo_len_bad_in)
        nxt_state.code = CNSC_CODE_PDO_LEN;
      else if (preop_in)
        nxt_state.code = CNSC_CODE_PREOP;
      else
        nxt_state.code = CNSC_CODE_OK;
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      state_ff.cfg_err <= CNSC_RST_CFG_ERR;
      state_ff.code    <= CNSC_RST_CODE;
    end
    else
      state_ff <= nxt_state;
  end

  // code straight from the register
  assign network_state_code_register_out = state_ff.code;

  // assertions: each code shows one cycle after its condition, unless a higher one masks it
  AST_INACTIVE_ZERO: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    master_role_in && !master_active_in |=> network_state_code_register_out == 8'h00)
    else $error("inactive master not zero");
  AST_NO_SLAVE: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    master_role_in && master_active_in && slave_count_in == 7'h00 && !mem_fault_in
    && !bus_off_in && !id_bad(own_node_id_in) && !tx_full_in && !rx_full_in
    && !cfg_loading_in && !cfg_bad_in && !state_ff.cfg_err
    |=> network_state_code_register_out == 8'hF1)
    else $error("empty list not F1");
  AST_M_LOAD: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    network_state_code_register_out == 8'hF2
    |-> $past(cfg_loading_in) && $past(master_role_in))
    else $error("F2 without download");

  // sticky flag: kept until a new download, and a fresh fault always lands
  AST_CFG_STICKY: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    state_ff.cfg_err && !cfg_loading_in |=> state_ff.cfg_err)
    else $error("config error dropped early");
  AST_CFG_SET: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    cfg_bad_in |=> state_ff.cfg_err)
    else $error("config fault not latched");

  // conditions shared by both roles, plus the master-only F5 and F8
  AST_BUS_OFF: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    bus_off_in && !(master_role_in && (!master_active_in || mem_fault_in))
    |=> network_state_code_register_out == 8'hF4)
    else $error("bus-off not F4");
  AST_BAD_ID: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    network_state_code_register_out == 8'hF5 |-> $past(id_bad(own_node_id_in)))
    else $error("F5 with legal id");
  AST_MEM: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    master_role_in && master_active_in && mem_fault_in
    |=> network_state_code_register_out == 8'hF8)
    else $error("memory fault not F8");
  AST_TX_FULL: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    network_state_code_register_out == 8'hFB |-> $past(tx_full_in))
    else $error("FB without full buffer");
  AST_RX_FULL: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    network_state_code_register_out == 8'hFC |-> $past(rx_full_in) && !$past(tx_full_in))
    else $error("FC wrongly chosen");

  // slave code set
  AST_INIT: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    !master_role_in && initializing_in && !bus_off_in && !tx_full_in && !rx_full_in
    |=> network_state_code_register_out == 8'hA0)
    else $error("init not A0");
  AST_PREOP: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    network_state_code_register_out == 8'hA1
    |-> $past(preop_in) && !$past(master_role_in))
    else $error("A1 without pre-operational state");
  AST_S_LOAD: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    !master_role_in && cfg_loading_in && !cfg_done_in && !bus_off_in && !tx_full_in
    && !rx_full_in && !initializing_in
    |=> network_state_code_register_out == 8'hA3)
    else $error("slave download not A3");
  AST_PDO_LEN: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    network_state_code_register_out == 8'hB1
    |-> $past(pdo_len_bad_in) && !$past(hb_tout))
    else $error("B1 without length mismatch");
  AST_HB: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    network_state_code_register_out == 8'hB0 |-> $past(hb_tout))
    else $error("B0 without timeout");
  AST_SLAVE_SET: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    network_state_code_register_out inside {8'hA0, 8'hA1, 8'hA3, 8'hB0, 8'hB1}
    |-> !$past(master_role_in))
    else $error("slave code in master role");
  AST_IDLE_ZERO: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    !master_role_in && !bus_off_in && !tx_full_in && !rx_full_in && !initializing_in
    && !cfg_loading_in && !hb_tout && !pdo_len_bad_in && !preop_in
    |=> network_state_code_register_out == 8'h00)
    else $error("quiet slave not zero");

  COV_MASTER_OK: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    master_role_in && master_active_in ##1 network_state_code_register_out == 8'h00);
  COV_CFG_ERR: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    network_state_code_register_out == 8'hF3);
  COV_PREOP: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    network_state_code_register_out == 8'hA1 ##1 network_state_code_register_out == 8'h00);
  COV_HB: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    network_state_code_register_out == 8'hB0);
  COV_BUS_OFF: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    network_state_code_register_out == 8'hF4);

endmodule // cnsc_status

// ### verilog/cnsc_pkg.sv
// shared constants and types for the node status code generator
package cnsc_pkg;

  // status codes
  localparam logic [7:0] CNSC_CODE_OK        = 8'h00;
  localparam logic [7:0] CNSC_CODE_NO_SLAVE  = 8'hF1;
  localparam logic [7:0] CNSC_CODE_M_LOAD    = 8'hF2;
  localparam logic [7:0] CNSC_CODE_CFG_ERR   = 8'hF3;
  localparam logic [7:0] CNSC_CODE_BUS_OFF   = 8'hF4;
  localparam logic [7:0] CNSC_CODE_BAD_SET   = 8'hF5;
  localparam logic [7:0] CNSC_CODE_MEM_ERR   = 8'hF8;
  localparam logic [7:0] CNSC_CODE_TX_FULL   = 8'hFB;
  localparam logic [7:0] CNSC_CODE_RX_FULL   = 8'hFC;
  localparam logic [7:0] CNSC_CODE_INIT      = 8'hA0;
  localparam logic [7:0] CNSC_CODE_PREOP     = 8'hA1;
  localparam logic [7:0] CNSC_CODE_S_LOAD    = 8'hA3;
  localparam logic [7:0] CNSC_CODE_HB_TOUT   = 8'hB0;
  localparam logic [7:0] CNSC_CODE_PDO_LEN   = 8'hB1;

  // node address limits
  localparam logic [7:0] CNSC_NODE_MIN       = 8'h01;
  localparam logic [7:0] CNSC_NODE_MAX       = 8'h7F;

  // reset values
  localparam logic [7:0] CNSC_RST_CODE       = 8'h00;
  localparam logic       CNSC_RST_CFG_ERR    = 1'b0;

  // heartbeat monitor: one tick is 1 ms
  localparam int         CNSC_CLK_MHZ        = 100;
  localparam int         CNSC_TICK_US        = 1000;
  localparam int         CNSC_TICK_CYC       = CNSC_TICK_US * CNSC_CLK_MHZ;
  localparam logic [16:0] CNSC_RST_TICK      = 17'h00000;
  localparam logic [15:0] CNSC_RST_HB_CNT    = 16'h0000;

endpackage

// ### verilog/cnsc_hb_monitor.sv
// heartbeat consumer timer: flags a missed heartbeat
`timescale 1ns/1ns
module cnsc_hb_monitor
  import cnsc_pkg::*;
#(
  parameter int TICK_CYC = CNSC_TICK_CYC
)
(
  // clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        rst_n_in,
  // control
  input  wire logic        hb_enable_in,
  input  wire logic [15:0] hb_time_ms_in,
  input  wire logic        hb_seen_in,
  // result
  output logic             hb_timeout_out
);

  typedef struct packed {
    logic [16:0] tick;
    logic [15:0] ms;
    logic        tout;
  } cnsc_hb_state_type;

  cnsc_hb_state_type state_ff;
  cnsc_hb_state_type nxt_state;

  // ms prescaler and elapsed counter; a heartbeat restarts both
  always_comb
  begin
    nxt_state = state_ff;
    if (!hb_enable_in || hb_seen_in || hb_time_ms_in == 16'h0000)
    begin
      nxt_state.tick = CNSC_RST_TICK;
      nxt_state.ms   = CNSC_RST_HB_CNT;
      nxt_state.tout = 1'b0;
    end
    else if (state_ff.tick == 17'(TICK_CYC - 1))
    begin
      nxt_state.tick = CNSC_RST_TICK;
      if (state_ff.ms != hb_time_ms_in)
        nxt_state.ms = state_ff.ms + 16'h0001;
    end
    else
      nxt_state.tick = state_ff.tick + 17'h00001;
    // timeout holds until a heartbeat arrives, the monitor is disabled or the time is zero
    if (hb_enable_in && !hb_seen_in && hb_time_ms_in != 16'h0000
        && state_ff.ms == hb_time_ms_in)
      nxt_state.tout = 1'b1;
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
      state_ff <= '0;
    else
      state_ff <= nxt_state;
  end

  assign hb_timeout_out = state_ff.tout;

endmodule // cnsc_hb_monitor

// ### tb/cnsc_hb_source.sv
// far-side node model: sends a heartbeat pulse every PERIOD cycles
`timescale 1ns/1ns
module cnsc_hb_source
#(
  parameter int PERIOD = 5
)
(
  // clock and reset
  input  wire logic ref_clk_in,
  input  wire logic rst_n_in,
  // control
  input  wire logic run_in,
  // heartbeat
  output logic      hb_seen_out
);
  int cnt_ff;

  // free period counter; a stopped node simply goes silent
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in || !run_in)
      cnt_ff <= 0;
    else
      cnt_ff <= (cnt_ff == PERIOD - 1) ? 0 : cnt_ff + 1;
    hb_seen_out <= rst_n_in && run_in && (cnt_ff == PERIOD - 1);
  end
endmodule // cnsc_hb_source

// ### tb/cnsc_status_bench.sv
// self-checking bench for the node status code generator
`timescale 1ns/1ns
module cnsc_status_bench;
  import cnsc_pkg::*;
  logic        clk = 1'b0, rst_n = 1'b0, mrole = 1'b1, mact = 1'b1;
  logic        load = 1'b0, done = 1'b0, cbad = 1'b0, boff = 1'b0, memf = 1'b0;
  logic        txf = 1'b0, rxf = 1'b0, init = 1'b0, preop = 1'b0, pdo = 1'b0;
  logic        hben = 1'b0, hb, hb_go = 1'b0;
  logic [6:0]  nslv = 7'h01;
  logic [7:0]  nid = 8'h01, code;
  logic [15:0] hbt = 16'h0002;
  int          error_cnt = 0, checks_done = 0;

  // clock at 100 MHz
  always #5 clk = ~clk;

  // short tick so a 2 ms window is 20 cycles
  cnsc_status #(.TICK_CYC(10)) cnsc_status_i (
    .ref_clk_in(clk), .rst_n_in(rst_n), .master_role_in(mrole),
    .master_active_in(mact), .slave_count_in(nslv), .cfg_loading_in(load),
    .cfg_done_in(done), .cfg_bad_in(cbad), .own_node_id_in(nid),
    .bus_off_in(boff), .mem_fault_in(memf), .tx_full_in(txf), .rx_full_in(rxf),
    .initializing_in(init), .preop_in(preop), .pdo_len_bad_in(pdo),
    .hb_enable_in(hben), .hb_time_ms_in(hbt), .hb_seen_in(hb),
    .network_state_code_register_out(code));

  cnsc_hb_source #(.PERIOD(5)) cnsc_hb_source_i (
    .ref_clk_in(clk), .rst_n_in(rst_n), .run_in(hb_go), .hb_seen_out(hb));

  // inputs move 1 ns after the edge, outputs read there too
  task automatic step(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask

  task automatic see(string what, logic [7:0] exp);
    step(2);
    check(what, code, exp);
  endtask

  task automatic summarize();
    if (error_cnt == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // master: everything on, then peel off in priority order
  task automatic master_prio();
    mrole = 1'b1;
    mact = 1'b0;
    boff = 1'b1;
    see("inactive", CNSC_CODE_OK);
    mact = 1'b1;
    memf = 1'b1;
    nid = 8'h00;
    txf = 1'b1;
    rxf = 1'b1;
    load = 1'b1;
    cbad = 1'b1;
    nslv = 7'h00;
    see("mem", CNSC_CODE_MEM_ERR);
    memf = 1'b0;
    see("busoff", CNSC_CODE_BUS_OFF);
    boff = 1'b0;
    see("badid", CNSC_CODE_BAD_SET);
    nid = 8'h01;
    see("tx", CNSC_CODE_TX_FULL);
    txf = 1'b0;
    see("rx", CNSC_CODE_RX_FULL);
    rxf = 1'b0;
    see("load", CNSC_CODE_M_LOAD);
    done = 1'b1;
    see("loaddone", CNSC_CODE_CFG_ERR);
    load = 1'b0;
    done = 1'b0;
    cbad = 1'b0;
    see("sticky", CNSC_CODE_CFG_ERR);
    load = 1'b1;
    see("reload", CNSC_CODE_M_LOAD);
    load = 1'b0;
    see("empty", CNSC_CODE_NO_SLAVE);
    nslv = 7'h01;
    see("normal", CNSC_CODE_OK);
  endtask

  // own address boundaries around 1..127
  task automatic master_ids();
    logic [7:0] ids [5] = '{8'h00, 8'h01, 8'h7F, 8'h80, 8'hFF};
    logic [7:0] exp [5] = '{CNSC_CODE_BAD_SET, CNSC_CODE_OK, CNSC_CODE_OK,
                            CNSC_CODE_BAD_SET, CNSC_CODE_BAD_SET};
    foreach (ids[i])
    begin
      nid = ids[i];
      see("nodeid", exp[i]);
    end
    nid = 8'h01;
  endtask

  // slave: master-only faults ignored, then peel in priority order
  // sticky config error must not survive a reset in mid-run
  task automatic mid_reset();
    cbad = 1'b1;
    see("cfgbad", CNSC_CODE_CFG_ERR);
    cbad = 1'b0;
    rst_n = 1'b0;
    step(2);
    check("midreset", code, CNSC_RST_CODE);
    rst_n = 1'b1;
    see("afterreset", CNSC_CODE_OK);
  endtask

  task automatic slave_prio();
    mrole = 1'b0;
    mact = 1'b0;
    memf = 1'b1;
    nslv = 7'h00;
    nid = 8'h00;
    see("slaveidle", CNSC_CODE_OK);
    memf = 1'b0;
    nslv = 7'h01;
    nid = 8'h01;
    hben = 1'b1;
    hb_go = 1'b0;
    boff = 1'b1;
    txf = 1'b1;
    rxf = 1'b1;
    init = 1'b1;
    load = 1'b1;
    pdo = 1'b1;
    preop = 1'b1;
    step(30);
    see("sbusoff", CNSC_CODE_BUS_OFF);
    boff = 1'b0;
    see("stx", CNSC_CODE_TX_FULL);
    txf = 1'b0;
    see("srx", CNSC_CODE_RX_FULL);
    rxf = 1'b0;
    see("init", CNSC_CODE_INIT);
    init = 1'b0;
    see("sload", CNSC_CODE_S_LOAD);
    done = 1'b1;
    see("sloaddone", CNSC_CODE_HB_TOUT);
    load = 1'b0;
    done = 1'b0;
    see("hbto", CNSC_CODE_HB_TOUT);
    hb_go = 1'b1;
    step(8);
    see("pdolen", CNSC_CODE_PDO_LEN);
    pdo = 1'b0;
    see("preop", CNSC_CODE_PREOP);
    preop = 1'b0;
    see("sok", CNSC_CODE_OK);
  endtask

  // last pulse lands 3 edges before the stop; flag 21 edges later, code one more
  task automatic slave_hb_time();
    step(10);
    hb_go = 1'b0;
    step(18);
    check("hbearly", code, CNSC_CODE_OK);
    step(1);
    check("hblate", code, CNSC_CODE_HB_TOUT);
    hb_go = 1'b1;
    step(8);
    check("hbback", code, CNSC_CODE_OK);
  endtask

  // reset held 8 cycles, then the scenarios
  initial
  begin
    repeat (8) @(posedge clk);
    #1;
    check("reset", code, CNSC_RST_CODE);
    rst_n = 1'b1;
    master_prio();
    master_ids();
    mid_reset();
    slave_prio();
    slave_hb_time();
    summarize();
  end

  // watchdog well beyond the about 145 cycles needed
  initial
  begin
    #100000;
    error_cnt++;
    summarize();
  end
endmodule // cnsc_status_bench
